// file: verilog/sbc_pkg.sv
// constants and types for the channel-b shunt converter register bank
package sbc_pkg;

	// ****************************************
	// register indices (byte address = 4 x index)
	// ****************************************
	localparam logic [9:0] IDX_CFG1    = 10'h0C2;  // channel configuration one
	localparam logic [9:0] IDX_CFG2    = 10'h0C3;  // channel configuration two
	localparam logic [9:0] IDX_TRIM_HI = 10'h0C4;  // offset trim bits 23:8
	localparam logic [9:0] IDX_TRIM_LO = 10'h0C5;  // offset trim bits 7:0
	localparam logic [9:0] IDX_CTRL    = 10'h0F0;  // start strobe
	localparam logic [9:0] IDX_STAT    = 10'h0F1;  // counter and state
	localparam logic [9:0] IDX_RESULT  = 10'h0F2;  // corrected result

	// ****************************************
	// reset values and writable masks
	// ****************************************
	localparam logic [15:0] RST_CFG1    = 16'h0400;
	localparam logic [15:0] RST_CFG2    = 16'h8010;
	localparam logic [15:0] RST_TRIM    = 16'h0000;
	localparam logic [15:0] MSK_CFG1    = 16'h0F0F;
	localparam logic [15:0] MSK_CFG2    = 16'h8F3F;
	localparam logic [15:0] MSK_TRIM_HI = 16'hFFFF;
	localparam logic [15:0] MSK_TRIM_LO = 16'hFF00;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CONV_KIND_BIT = 11;  // cfg1: conversion kind
	localparam int OSR_LSB       = 8;   // cfg1: oversampling 10:8
	localparam int CHOP_EN_BIT   = 3;   // cfg1: global chop enable
	localparam int CHOP_DLY_LSB  = 0;   // cfg1: chop delay 2:0
	localparam int CH_EN_BIT     = 15;  // cfg2: channel enable
	localparam int GAIN_LSB      = 10;  // cfg2: gain 11:10
	localparam int MUX_LSB       = 8;   // cfg2: input select 9:8
	localparam int SRC_ROUTE_BIT = 5;   // cfg2: probe source route
	localparam int SNK_ROUTE_BIT = 4;   // cfg2: probe sink route
	localparam int SRC_LVL_LSB   = 2;   // cfg2: probe source level
	localparam int SNK_LVL_LSB   = 0;   // cfg2: probe sink level
	localparam int START_BIT     = 0;   // ctrl: start one conversion

	// ****************************************
	// timing and codes
	// ****************************************
	localparam logic [13:0] OSR_BASE   = 14'h0040;  // ratio for code 000b
	localparam logic [8:0]  CHOP_BASE  = 9'h002;    // periods for code 000b
	localparam logic [1:0]  GAIN_8     = 2'h1;      // analog gain code for 8
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLV   = 2'h2;
	localparam int          MOD_DIV    = 2;         // aclk cycles per mod period

	typedef enum logic [1:0] {SBC_IDLE, SBC_SETTLE, SBC_ACCUM} sbc_state_e;

endpackage : sbc_pkg

// file: verilog/sbc_regs.sv
// channel-b shunt converter configuration bank with axi4-lite slave
// Function
// - conversion kind: 0 continuous, 1 single
// - oversampling 64..8192, rate is fmod/ratio with chop off, fmod/(ratio + delay) with chop on
// - global chop on when bit set
// - chop delay 2 to 256 periods, doubling per code
// - disable or standby clears result, counter
// - gain codes give 4, 8, 16, 32
// - gains 16, 32: analog 8, rest digital
// - input select: normal, swapped, ground, test
// - source route: 0 positive, 1 negative
// - sink route likewise, resets to negative
// - source level off, 4, 40, 240 uA
// - sink level off, 4, 40, 240 uA
// - trim bits 23:8 fill first word
// - trim bits 7:0 in 15:8, rest zero
// - trim is 24-bit two's complement
// - first configuration word resets to 0400h
// - second configuration word resets to 8010h
`timescale 1ns/10ps
`default_nettype none
module sbc_regs #(
	parameter int ADDR_W = 12  // axi address width
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [ADDR_W-1:0]  s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire logic               standby,
	input  wire logic [23:0]        raw_data,
	input  wire logic               raw_valid,
	output logic                    conv_done,
	output logic                    chop_phase,
	output logic                    conversion_kind_sel,
	output logic [13:0]             oversampling_ratio,
	output logic                    global_chop_enable,
	output logic [8:0]              chop_delay_periods,
	output logic                    channel_on,
	output logic [1:0]              analog_gain_sel,
	output logic [1:0]              digital_shift,
	output logic                    shunt_pins_connected,
	output logic                    shunt_inputs_swapped,
	output logic                    analog_ground_short,
	output logic                    test_source_routed,
	output logic                    probe_source_route,
	output logic                    probe_sink_route,
	output logic [1:0]              probe_source_level,
	output logic [1:0]              probe_sink_level,
	output logic [23:0]             offset_trim,
	output logic [23:0]             result,
	output logic [1:0]              conversion_counter
);
	import sbc_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	// ratio from the 3-bit oversampling code
	function automatic logic [13:0] osr_ratio(input logic [2:0] code);
		osr_ratio = OSR_BASE << code;
	endfunction : osr_ratio

	// settle periods from the 3-bit delay code
	function automatic logic [8:0] chop_len(input logic [2:0] code);
		chop_len = CHOP_BASE << code;
	endfunction : chop_len

	// masked byte-lane merge of a write into a 16-bit word
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] st, input logic [15:0] msk);
		logic [15:0] v;
		v = old;
		if (st[0]) begin
			v[7:0] = wd[7:0];
		end
		if (st[1]) begin
			v[15:8] = wd[15:8];
		end
		merge16 = v & msk;
	endfunction : merge16

	// ****************************************
	// registers
	// ****************************************
	logic [15:0]       cfg1_r;     // configuration word one
	logic [15:0]       cfg2_r;     // configuration word two
	logic [15:0]       trim_hi_r;  // trim bits 23:8
	logic [15:0]       trim_lo_r;  // trim bits 7:0 in 15:8
	logic              aw_got_r;   // write address held
	logic              w_got_r;    // write data held
	logic [9:0]        wr_idx_r;   // held write index
	logic [31:0]       wdat_r;     // held write data
	logic [3:0]        wstb_r;     // held strobes
	logic              bvalid_r;   // write response pending
	logic [1:0]        bresp_r;    // write response code
	logic              rvalid_r;   // read data pending
	logic [31:0]       rdata_r;    // read data
	logic [1:0]        rresp_r;    // read response code
	logic              start_r;    // one-cycle start pulse
	logic [23:0]       result_r;   // corrected result
	logic [1:0]        cnt_r;      // conversion counter
	sbc_state_e        state_r;    // sequencer state
	logic [13:0]       acc_r;      // mod periods in this conversion
	logic [8:0]        settle_r;   // mod periods settled
	logic [7:0]        div_r;      // modulator divider
	logic              done_r;     // conversion boundary pulse
	logic              phase_r;    // chop input polarity

	logic              wr_fire;    // both halves of a write present
	logic              wr_hit;     // write index is a writable register
	logic              mod_tick;   // one pulse per modulator period
	logic [23:0]       gained;     // raw after digital gain

	// ****************************************
	// field decode
	// ****************************************
	assign conversion_kind_sel  = cfg1_r[CONV_KIND_BIT];
	assign oversampling_ratio   = osr_ratio(cfg1_r[OSR_LSB+:3]);
	assign global_chop_enable   = cfg1_r[CHOP_EN_BIT];
	assign chop_delay_periods   = chop_len(cfg1_r[CHOP_DLY_LSB+:3]);
	// converter runs only when enabled and out of standby
	assign channel_on           = cfg2_r[CH_EN_BIT] & ~standby;
	// gain 16 and 32 keep the analog stage at 8
	assign analog_gain_sel      = cfg2_r[GAIN_LSB+1] ? GAIN_8
	                                                 : cfg2_r[GAIN_LSB+:2];
	assign digital_shift        = cfg2_r[GAIN_LSB+1] ? {1'b0, cfg2_r[GAIN_LSB]} + 2'h1
	                                                 : 2'h0;
	// pins are cut off for ground short and test source
	assign shunt_pins_connected = ~cfg2_r[MUX_LSB+1];
	assign shunt_inputs_swapped = cfg2_r[MUX_LSB+:2] == 2'h1;
	assign analog_ground_short  = cfg2_r[MUX_LSB+:2] == 2'h2;
	assign test_source_routed   = cfg2_r[MUX_LSB+:2] == 2'h3;
	assign probe_source_route   = cfg2_r[SRC_ROUTE_BIT];
	assign probe_sink_route     = cfg2_r[SNK_ROUTE_BIT];
	assign probe_source_level   = cfg2_r[SRC_LVL_LSB+:2];
	assign probe_sink_level     = cfg2_r[SNK_LVL_LSB+:2];
	assign offset_trim          = {trim_hi_r, trim_lo_r[15:8]};

	// ****************************************
	// axi write channel
	// ****************************************
	// halves are taken in either order, none while a response waits
	assign s_axi_awready = ~aw_got_r & ~bvalid_r;
	assign s_axi_wready  = ~w_got_r & ~bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign wr_fire       = aw_got_r & w_got_r;
	assign wr_hit        = wr_idx_r inside {IDX_CFG1, IDX_CFG2, IDX_TRIM_HI,
	                                        IDX_TRIM_LO, IDX_CTRL};

	// address half capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			wr_idx_r <= 10'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_got_r <= 1'b1;
			wr_idx_r <= s_axi_awaddr[11:2];
		end else if (wr_fire) begin
			aw_got_r <= 1'b0;
		end
	end

	// data half capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got_r <= 1'b0;
			wdat_r  <= 32'h0000_0000;
			wstb_r  <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_got_r <= 1'b1;
			wdat_r  <= s_axi_wdata;
			wstb_r  <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_got_r <= 1'b0;
		end
	end

	// response after both halves; unmapped gives slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLV;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// ****************************************
	// configuration storage
	// ****************************************
	// reserved bits are masked off, so they never hold a one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg1_r    <= RST_CFG1;
			cfg2_r    <= RST_CFG2;
			trim_hi_r <= RST_TRIM;
			trim_lo_r <= RST_TRIM;
		end else if (wr_fire) begin
			if (wr_idx_r == IDX_CFG1) begin
				cfg1_r <= merge16(cfg1_r, wdat_r, wstb_r, MSK_CFG1);
			end
			if (wr_idx_r == IDX_CFG2) begin
				cfg2_r <= merge16(cfg2_r, wdat_r, wstb_r, MSK_CFG2);
			end
			if (wr_idx_r == IDX_TRIM_HI) begin
				trim_hi_r <= merge16(trim_hi_r, wdat_r, wstb_r, MSK_TRIM_HI);
			end
			if (wr_idx_r == IDX_TRIM_LO) begin
				trim_lo_r <= merge16(trim_lo_r, wdat_r, wstb_r, MSK_TRIM_LO);
			end
		end
	end

	// start strobe: write one to bit 0 of the control word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_r <= 1'b0;
		end else begin
			start_r <= wr_fire && wr_idx_r == IDX_CTRL && wstb_r[0]
			           && wdat_r[START_BIT];
		end
	end

	// ****************************************
	// axi read channel
	// ****************************************
	// one read at a time; data registered one cycle after address
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	// read mux; upper half reads zero for every word but the result, which carries bits 23:16
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rresp_r  <= RESP_OKAY;
			unique case (s_axi_araddr[11:2])
				IDX_CFG1: begin
					rdata_r <= {16'h0000, cfg1_r};
				end
				IDX_CFG2: begin
					rdata_r <= {16'h0000, cfg2_r};
				end
				IDX_TRIM_HI: begin
					rdata_r <= {16'h0000, trim_hi_r};
				end
				IDX_TRIM_LO: begin
					rdata_r <= {16'h0000, trim_lo_r};
				end
				IDX_CTRL: begin
					rdata_r <= 32'h0000_0000;
				end
				IDX_STAT: begin
					rdata_r <= {26'h000_0000, phase_r, channel_on, state_r, cnt_r};
				end
				IDX_RESULT: begin
					rdata_r <= {8'h00, result_r};
				end
				default: begin
					rdata_r <= 32'h0000_0000;
					rresp_r <= RESP_SLV;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// ****************************************
	// modulator timing and sequencer
	// ****************************************
	assign mod_tick   = div_r == 8'(MOD_DIV - 1);
	assign conv_done  = done_r;
	assign chop_phase = phase_r;

	// modulator period divider
	always_ff @(posedge aclk) begin
		if (!aresetn || mod_tick) begin
			div_r <= 8'h00;
		end else begin
			div_r <= div_r + 8'h01;
		end
	end

	// settle when chop is on, then accumulate ratio periods; single mode stops after one
	always_ff @(posedge aclk) begin
		if (!aresetn || !channel_on) begin
			state_r  <= SBC_IDLE;
			acc_r    <= 14'h0000;
			settle_r <= 9'h000;
			done_r   <= 1'b0;
			phase_r  <= 1'b0;
		end else begin
			done_r <= 1'b0;
			unique case (state_r)
				SBC_IDLE: begin
					// continuous restarts itself, single waits for start
					if (!conversion_kind_sel || start_r) begin
						state_r  <= global_chop_enable ? SBC_SETTLE : SBC_ACCUM;
						settle_r <= 9'h000;
						acc_r    <= 14'h0000;
					end
				end
				SBC_SETTLE: begin
					// chop delay lets the swapped input settle
					if (mod_tick) begin
						settle_r <= settle_r + 9'h001;
						if (settle_r == chop_delay_periods - 9'h001) begin
							state_r <= SBC_ACCUM;
						end
					end
				end
				SBC_ACCUM: begin
					if (mod_tick) begin
						acc_r <= acc_r + 14'h0001;
						if (acc_r == oversampling_ratio - 14'h0001) begin
							done_r   <= 1'b1;
							acc_r    <= 14'h0000;
							phase_r  <= global_chop_enable & ~phase_r;
							settle_r <= 9'h000;
							if (conversion_kind_sel) begin
								state_r <= SBC_IDLE;
							end else if (global_chop_enable) begin
								state_r <= SBC_SETTLE;
							end
						end
					end
				end
			endcase
		end
	end

	// ****************************************
	// result path
	// ****************************************
	// digital gain wraps on overflow; no saturation is applied
	assign gained = raw_data << digital_shift;

	// trim is subtracted as signed 24 bits; cleared while off
	always_ff @(posedge aclk) begin
		if (!aresetn || !channel_on) begin
			result_r <= 24'h00_0000;
			cnt_r    <= 2'h0;
		end else if (raw_valid) begin
			result_r <= gained - offset_trim;
			cnt_r    <= cnt_r + 2'h1;
		end
	end

	assign result             = result_r;
	assign conversion_counter = cnt_r;

	// ****************************************
	// checks
	// ****************************************
	a_off_clears: assert property (@(posedge aclk) disable iff (!aresetn)
		!channel_on |=> (result == 24'h00_0000 && conversion_counter == 2'h0))
		else $error("result not cleared while channel off");

	a_trim_subtract: assert property (@(posedge aclk) disable iff (!aresetn)
		(channel_on && raw_valid) ##1 channel_on
		|-> result == $past(gained) - $past(offset_trim))
		else $error("result is not raw minus trim");

	a_cfg_reset: assert property (@(posedge aclk)
		!aresetn |=> (cfg1_r == 16'h0400 && cfg2_r == 16'h8010))
		else $error("configuration reset value wrong");

	a_lo_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
		trim_lo_r[7:0] == 8'h00 && cfg1_r[15:12] == 4'h0 && cfg2_r[7:6] == 2'h0)
		else $error("reserved bits hold a one");

	a_ratio_map: assert property (@(posedge aclk) disable iff (!aresetn)
		oversampling_ratio == (14'h0040 << cfg1_r[10:8]))
		else $error("oversampling ratio decode wrong");

	a_gain_split: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg2_r[11] |-> (analog_gain_sel == 2'h1 && digital_shift == cfg2_r[11:10] - 2'h1))
		else $error("high gain not split as analog eight");

	// a start or a mode change right after the window may rightly leave idle
	a_single_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		(done_r && conversion_kind_sel && $past(conversion_kind_sel) && channel_on && !start_r)
		|-> state_r == SBC_IDLE ##1 state_r == SBC_IDLE)
		else $error("single conversion did not stop");

	a_chop_settle: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_r == SBC_SETTLE && mod_tick && channel_on
		 && settle_r == chop_delay_periods - 9'h001) |=> state_r == SBC_ACCUM)
		else $error("chop settle did not end on time");

	a_bresp_both: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(bvalid_r) |-> $past(aw_got_r) && $past(w_got_r))
		else $error("write answered before both halves");

	a_trim_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		!wr_fire |=> $stable(offset_trim))
		else $error("trim changed without a write");

endmodule : sbc_regs
`default_nettype wire

// file: verilog/sbc_dummy_unused.sv
// intentionally empty compilation unit

// file: verif/test_shunt_adc_b_config_regs.sv
// self-checking bench for the channel-b shunt converter register bank
`timescale 1ns/10ps
`default_nettype none
module test_shunt_adc_b_config_regs;
	import sbc_pkg::*;
	// ****************************************
	// signals
	// ****************************************
	logic        aclk = 1'b0;                        // free-running clock
	logic        aresetn, standby, raw_valid;        // reset, side inputs
	logic        conv_done, chop_phase;              // sequencer outputs
	int          waited;                             // cycles spent waiting
	logic [11:0] s_axi_awaddr, s_axi_araddr;          // byte addresses
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [23:0] raw_data, offset_trim, result;
	logic        conversion_kind_sel, global_chop_enable, channel_on, probe_source_route;
	logic        shunt_pins_connected, shunt_inputs_swapped, analog_ground_short;
	logic        test_source_routed, probe_sink_route;
	logic [13:0] oversampling_ratio;
	logic [8:0]  chop_delay_periods;
	logic [1:0]  analog_gain_sel, digital_shift, probe_source_level, probe_sink_level;
	logic [1:0]  conversion_counter;
	int          miscompares = 0;            // mismatches seen
	int          checks      = 0;            // comparisons made
	int          seed        = 32'h6CBB2F93; // fixed so runs repeat
	logic [31:0] w;                          // write value under test
	logic [23:0] raw, trim;                  // stimulus for one conversion
	logic [1:0]  cnt;                        // expected counter

	sbc_regs i_sbc_regs (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .standby, .raw_data, .raw_valid,
		.conv_done, .chop_phase, .conversion_kind_sel, .oversampling_ratio,
		.global_chop_enable, .chop_delay_periods, .channel_on, .analog_gain_sel, .digital_shift,
		.shunt_pins_connected, .shunt_inputs_swapped, .analog_ground_short, .test_source_routed,
		.probe_source_route, .probe_sink_route, .probe_source_level, .probe_sink_level,
		.offset_trim, .result, .conversion_counter);

	always #50 aclk = ~aclk;  // 10 MHz

	// ****************************************
	// compare and expectation helpers
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: response %h expected %h", $time, got, exp);
		end
	endtask : chk_resp

	// digital part of the gain: 16 and 32 are 8 shifted up
	function automatic logic [1:0] dsh(input logic [1:0] g);
		return (g == 2'h3) ? 2'h2 : (g == 2'h2) ? 2'h1 : 2'h0;
	endfunction : dsh

	function automatic logic [23:0] exp_res(input logic [23:0] r, input logic [1:0] s,
		input logic [23:0] t);
		return (r << s) - t;
	endfunction : exp_res

	// ****************************************
	// bus cycles: ready is looked at on the falling edge, so the taking edge is known
	// ****************************************
	task automatic wr(input logic [9:0] ix, input logic [31:0] dat, input logic [1:0] er);
		int   n;
		logic ha, hw, hb;
		logic [1:0] rr;
		n  = 0;
		hb = 1'b0;
		@(posedge aclk);
		s_axi_awaddr  <= {ix, 2'h0};
		s_axi_awvalid <= 1'b1;
		s_axi_wdata   <= dat;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		while (!hb && n < 200) begin
			@(negedge aclk);
			ha = s_axi_awvalid & s_axi_awready;
			hw = s_axi_wvalid & s_axi_wready;
			hb = s_axi_bvalid;
			rr = s_axi_bresp;
			@(posedge aclk);
			if (ha) s_axi_awvalid <= 1'b0;
			if (hw) s_axi_wvalid <= 1'b0;
			n++;
		end
		s_axi_bready <= 1'b0;
		if (!hb) miscompares++;
		chk_resp(rr, er);
	endtask : wr

	task automatic rd(input logic [9:0] ix, input logic [31:0] ex, input logic [1:0] er);
		int   n;
		logic ha, hr;
		logic [31:0] dd;
		logic [1:0]  rr;
		n  = 0;
		hr = 1'b0;
		@(posedge aclk);
		s_axi_araddr  <= {ix, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		while (!hr && n < 200) begin
			@(negedge aclk);
			ha = s_axi_arvalid & s_axi_arready;
			hr = s_axi_rvalid;
			dd = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge aclk);
			if (ha) s_axi_arvalid <= 1'b0;
			n++;
		end
		s_axi_rready <= 1'b0;
		if (!hr) miscompares++;
		chk(dd, ex);
		chk_resp(rr, er);
	endtask : rd

	// one raw conversion; data line shows garbage once the pulse is over
	task automatic pulse(input logic [23:0] r);
		@(posedge aclk);
		raw_data  <= r;
		raw_valid <= 1'b1;
		@(posedge aclk);
		raw_valid <= 1'b0;
		raw_data  <= ~r;
		@(posedge aclk);
		@(negedge aclk);
	endtask : pulse

	task automatic print_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict

	// watchdog, far beyond the few hundred cycles the run needs
	initial begin
		#2000000;
		miscompares++;
		print_verdict();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		aresetn = 1'b0; standby = 1'b0; raw_valid = 1'b0; raw_data = 24'h0;
		s_axi_awaddr = 12'h0; s_axi_awvalid = 1'b0; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hF;
		s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_araddr = 12'h0; s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(IDX_CFG1, 32'h0400, RESP_OKAY);
		rd(IDX_CFG2, 32'h8010, RESP_OKAY);
		rd(IDX_TRIM_HI, 32'h0, RESP_OKAY);
		rd(IDX_TRIM_LO, 32'h0, RESP_OKAY);
		chk(32'(oversampling_ratio), 32'h400);
		chk(32'(probe_sink_route), 32'h1);
		// every oversampling and chop delay code, random other bits
		for (int i = 0; i < 8; i++) begin
			w = $random(seed);
			w[10:8] = i[2:0];
			w[2:0] = 3'(7 - i);
			wr(IDX_CFG1, w, RESP_OKAY);
			@(negedge aclk);
			chk(32'(oversampling_ratio), 32'h40 << i);
			chk(32'(chop_delay_periods), 32'h2 << (7 - i));
			chk(32'(conversion_kind_sel), 32'(w[11]));
			chk(32'(global_chop_enable), 32'(w[3]));
			rd(IDX_CFG1, w & 32'h0F0F, RESP_OKAY);
		end
		// every gain and input code, each with a trimmed conversion
		cnt = 2'h0;
		for (int g = 0; g < 4; g++) begin
			w = $random(seed);
			w[15] = 1'b1;
			w[11:8] = {g[1:0], g[1:0]};
			raw = (g == 3) ? 24'h7FFFFF : $random(seed);
			trim = (g == 3) ? 24'h800000 : $random(seed);
			wr(IDX_CFG2, w, RESP_OKAY);
			wr(IDX_TRIM_HI, {16'hFFFF, trim[23:8]}, RESP_OKAY);
			wr(IDX_TRIM_LO, {16'hFFFF, trim[7:0], 8'hA5}, RESP_OKAY);
			@(negedge aclk);
			chk(32'(analog_gain_sel), (g > 1) ? 32'h1 : 32'(g));
			chk(32'(digital_shift), 32'(dsh(g[1:0])));
			chk(32'({shunt_pins_connected, shunt_inputs_swapped, analog_ground_short,
				test_source_routed}), 32'({g < 2, g == 1, g == 2, g == 3}));
			chk(32'({probe_source_route, probe_sink_route, probe_source_level,
				probe_sink_level}), 32'(w[5:0]));
			chk(32'(offset_trim), 32'(trim));
			rd(IDX_CFG2, w & 32'h8F3F, RESP_OKAY);
			rd(IDX_TRIM_LO, {16'h0, trim[7:0], 8'h0}, RESP_OKAY);
			pulse(raw);
			cnt++;
			chk(32'(result), 32'(exp_res(raw, dsh(g[1:0]), trim)));
			chk(32'(conversion_counter), 32'(cnt));
		end
		// disabling clears result and counter, and freezes counting
		wr(IDX_CFG2, 32'h0010, RESP_OKAY);
		pulse(24'h000321);
		chk(32'({channel_on, conversion_counter, result}), 32'h0);
		wr(IDX_CFG2, 32'h8010, RESP_OKAY);
		pulse(24'h000123);
		chk(32'(result), 32'(exp_res(24'h000123, 2'h0, trim)));
		@(posedge aclk);
		standby <= 1'b1;
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		chk(32'({channel_on, conversion_counter, result}), 32'h0);
		@(posedge aclk);
		standby <= 1'b0;
		// single shot with chop: one start gives one window, then the sequencer idles
		wr(IDX_CFG2, 32'h0010, RESP_OKAY);
		wr(IDX_CFG1, 32'h0808, RESP_OKAY);
		wr(IDX_CFG2, 32'h8010, RESP_OKAY);
		rd(IDX_STAT, 32'h10, RESP_OKAY);
		wr(IDX_CTRL, 32'h1, RESP_OKAY);
		waited = 0;
		do begin
			@(negedge aclk);
			waited++;
		end while (!conv_done && waited < 400);
		// two settle and 64 window periods; the divider's phase adds less than one period
		waited -= (int'(CHOP_BASE) + int'(OSR_BASE)) * MOD_DIV;
		chk(32'(waited >= 0 && waited < MOD_DIV), 32'h1);
		chk(32'(chop_phase), 32'h1);
		// a continuous run would end another window well inside this span
		waited = 0;
		repeat (300) begin
			@(negedge aclk);
			waited += conv_done;
		end
		chk(32'(waited), 32'h0);
		rd(IDX_STAT, 32'h30, RESP_OKAY);
		pulse(24'h0ABCDE);
		rd(IDX_RESULT, {8'h00, exp_res(24'h0ABCDE, 2'h0, trim)}, RESP_OKAY);
		rd(IDX_STAT, 32'h31, RESP_OKAY);
		rd(IDX_CTRL, 32'h0, RESP_OKAY);
		// unmapped and read-only places
		wr(10'h000, 32'hFFFF, RESP_SLV);
		rd(10'h000, 32'h0, RESP_SLV);
		wr(IDX_RESULT, 32'h1, RESP_SLV);
		rd(IDX_CFG2, 32'h8010, RESP_OKAY);
		print_verdict();
	end
endmodule : test_shunt_adc_b_config_regs
`default_nettype wire
